// ### dfp_pkg.sv
package dfp_pkg;

    // ==========================================================
    // Register map (index = printed offset, byte addr = 4*index)
    // ==========================================================
    localparam logic [7:0] IDX_CONTROL = 8'h0c;
    localparam logic [7:0] IDX_DUTY_CH0 = 8'h0d;
    localparam logic [7:0] IDX_DUTY_CH1 = 8'h0e;
    localparam logic [7:0] IDX_STATUS = 8'h0f;
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_CONTROL = {2'b00, IDX_CONTROL, 2'b00};
    localparam logic [11:0] ADDR_DUTY_CH0 = {2'b00, IDX_DUTY_CH0, 2'b00};
    localparam logic [11:0] ADDR_DUTY_CH1 = {2'b00, IDX_DUTY_CH1, 2'b00};
    localparam logic [11:0] ADDR_STATUS = {2'b00, IDX_STATUS, 2'b00};

    // ==========================================================
    // Control field layout
    // ==========================================================
    localparam int POS_MODE = 0;
    localparam int POS_RUN = 3;
    localparam int POS_EN0 = 6;
    localparam int POS_EN1 = 7;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] DUTY_RESET = 8'h80;

    typedef enum logic [1:0] {
        DFP_RES_8BIT = 2'b00,
        DFP_RES_7BIT = 2'b01,
        DFP_RES_6BIT = 2'b10,
        DFP_RES_RSVD = 2'b11
    } dfp_res_e;

    typedef struct packed {
        logic out_en_ch1;
        logic out_en_ch0;
        logic [1:0] rsvd_hi;
        logic counter_run;
        logic rsvd_lo;
        dfp_res_e resolution_select;
    } dfp_ctrl_s;

    // ==========================================================
    // Timing: one source clock period spans two half steps
    // ==========================================================
    localparam real SRC_PERIOD_NS = 50.0;
    localparam real PCLK_PERIOD_NS = 8.0;
    localparam int HALF_CYC = 1;
    localparam int HALF_W = 9;

    // Pin signals of one channel
    typedef struct packed {
        logic level;
        logic oe;
    } dfp_pin_s;

endpackage : dfp_pkg

// ### dfp_half_tick.sv
module dfp_half_tick #(
    parameter int HALF_CYC = dfp_pkg::HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    output logic half_en
);
    localparam int CW = (HALF_CYC > 1) ? $clog2(HALF_CYC) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_CYC - 1);

    logic [CW-1:0] div_r;

    // Restart from zero on stop so the first period is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= '0;
        end else if (!run || div_r == LAST) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + CW'(1);
        end
    end

    assign half_en = run && (div_r == LAST);

endmodule // dfp_half_tick

// ### dfp_channel.sv
module dfp_channel (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic run,
    input wire logic load,
    input wire dfp_pkg::dfp_res_e res,
    input wire logic [7:0] duty,
    input wire logic [8:0] half_cnt,
    output logic level
);
    logic [7:0] duty_r;
    logic dither_r;
    logic [8:0] width_half;
    logic level_r;

    // Latch duty at a period boundary and on every cycle while stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_r <= dfp_pkg::DUTY_RESET;
        end else if (load) begin
            duty_r <= duty;
        end
    end

    // Alternates pulses for the quarter-clock average
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dither_r <= 1'b0;
        end else if (!run) begin
            dither_r <= 1'b0;
        end else if (load) begin
            dither_r <= ~dither_r;
        end
    end

    // Width in half source periods
    always_comb begin
        unique case (res)
            dfp_pkg::DFP_RES_8BIT: width_half = {duty_r, 1'b0};
            dfp_pkg::DFP_RES_7BIT: width_half = {1'b0, duty_r};
            dfp_pkg::DFP_RES_6BIT: width_half = {2'b00, duty_r[7:2], duty_r[1]} + 9'(duty_r[0] & dither_r);
            default: width_half = {duty_r, 1'b0};
        endcase
    end

    // Low for the width from period start, high after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b1;
        end else if (!run) begin
            level_r <= 1'b1;
        end else begin
            level_r <= !(half_cnt < width_half);
        end
    end

    assign level = level_r;

endmodule // dfp_channel

// ### dfp_top.sv
// Function
// - Two channels each make their own waveform from their own duty register.
// - Mode field 00/01/10 selects 8/7/6-bit period, 11 is reserved.
// - The run bit lets the shared up-counter count when 1 and stops it when 0.
// - While stopped the counter is held cleared and both pins show high.
// - Writing run as 0 returns every control field to its initial value.
// - Each channel has an output enable bit; software enables only while running.
// - One mode applies to both channels together.
// - 8-bit mode: 256 source periods, width is duty times one source period.
// - 7-bit mode: 128 source periods, upper seven bits plus a half period for bit 0.
// - 6-bit mode: 64 source periods, upper six bits plus a fractional extension.
// - 6-bit fractions come from half-period stretches averaged over pulses.
module dfp_top #(
    parameter int HALF_CYC = dfp_pkg::HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dfp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic pwm_out_ch0,
    output logic pwm_out_ch0_oe,
    output logic pwm_out_ch1,
    output logic pwm_out_ch1_oe
);

    // ==========================================================
    // Bus decode
    // ==========================================================
    logic setup_ph;
    logic access_ph;
    logic hit_ctrl;
    logic hit_d0;
    logic hit_d1;
    logic hit_stat;
    logic mapped;
    logic wr_ok;
    logic wr_ctrl;
    logic wr_d0;
    logic wr_d1;

    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign hit_ctrl = (paddr == dfp_pkg::ADDR_CONTROL);
    assign hit_d0 = (paddr == dfp_pkg::ADDR_DUTY_CH0);
    assign hit_d1 = (paddr == dfp_pkg::ADDR_DUTY_CH1);
    assign hit_stat = (paddr == dfp_pkg::ADDR_STATUS);
    assign mapped = hit_ctrl || hit_d0 || hit_d1 || hit_stat;

    // Register data sits in byte lane 0 only
    assign wr_ok = access_ph && pwrite && mapped && pstrb[0];
    assign wr_ctrl = wr_ok && hit_ctrl;
    assign wr_d0 = wr_ok && hit_d0;
    assign wr_d1 = wr_ok && hit_d1;

    // Zero wait states; status is read-only
    assign pready = 1'b1;
    assign pslverr = access_ph && (!mapped || (pwrite && hit_stat));

    // ==========================================================
    // Control register
    // ==========================================================
    dfp_pkg::dfp_ctrl_s ctrl_r;
    dfp_pkg::dfp_ctrl_s ctrl_wr;
    logic run;

    assign ctrl_wr = dfp_pkg::dfp_ctrl_s'(pwdata[7:0]);
    assign run = ctrl_r.counter_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= dfp_pkg::dfp_ctrl_s'(dfp_pkg::CONTROL_RESET);
        end else if (wr_ctrl) begin
            if (!ctrl_wr.counter_run) begin
                // Stop doubles as a software reset of the control register; duty registers keep their values
                ctrl_r <= dfp_pkg::dfp_ctrl_s'(dfp_pkg::CONTROL_RESET);
            end else if (!run) begin
                // Start: only the run bit takes effect on this write
                ctrl_r.counter_run <= 1'b1;
            end else begin
                // Enables and mode follow the write while running; reserved mode 11 is ignored
                ctrl_r.out_en_ch1 <= ctrl_wr.out_en_ch1;
                ctrl_r.out_en_ch0 <= ctrl_wr.out_en_ch0;
                if (ctrl_wr.resolution_select != dfp_pkg::DFP_RES_RSVD) begin
                    ctrl_r.resolution_select <= ctrl_wr.resolution_select;
                end
            end
        end
    end

    // ==========================================================
    // Duty registers
    // ==========================================================
    logic [7:0] duty_ch0_r;
    logic [7:0] duty_ch1_r;

    // Ignored while stopped: the block is not ready for setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_ch0_r <= dfp_pkg::DUTY_RESET;
        end else if (wr_d0 && run) begin
            duty_ch0_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            duty_ch1_r <= dfp_pkg::DUTY_RESET;
        end else if (wr_d1 && run) begin
            duty_ch1_r <= pwdata[7:0];
        end
    end

    // ==========================================================
    // Shared up-counter, in half source periods
    // ==========================================================
    logic half_en;
    logic [dfp_pkg::HALF_W-1:0] half_cnt_r;
    logic [dfp_pkg::HALF_W-1:0] half_last;
    logic boundary;
    logic load;

    dfp_half_tick #(
        .HALF_CYC(HALF_CYC)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .half_en(half_en)
    );

    // One mode sets the period for both channels
    always_comb begin
        unique case (ctrl_r.resolution_select)
            dfp_pkg::DFP_RES_8BIT: half_last = 9'h1ff;
            dfp_pkg::DFP_RES_7BIT: half_last = 9'h0ff;
            dfp_pkg::DFP_RES_6BIT: half_last = 9'h07f;
            default: half_last = 9'h1ff;
        endcase
    end

    assign boundary = half_en && (half_cnt_r == half_last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            half_cnt_r <= '0;
        end else if (!run) begin
            half_cnt_r <= '0;
        end else if (boundary) begin
            half_cnt_r <= '0;
        end else if (half_en) begin
            half_cnt_r <= half_cnt_r + 9'h001;
        end
    end

    // While stopped keep loading so the first period uses fresh data
    assign load = boundary || !run;

    // ==========================================================
    // Channels
    // ==========================================================
    logic [1:0] level;
    logic [7:0] duty_sel [2];

    assign duty_sel[0] = duty_ch0_r;
    assign duty_sel[1] = duty_ch1_r;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_ch
            dfp_channel u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .run(run),
                .load(load),
                .res(ctrl_r.resolution_select),
                .duty(duty_sel[ch]),
                .half_cnt(half_cnt_r),
                .level(level[ch])
            );
        end
    endgenerate

    // ==========================================================
    // Pins: enable only gates the driver, never the waveform
    // ==========================================================
    assign pwm_out_ch0 = level[0];
    assign pwm_out_ch1 = level[1];
    assign pwm_out_ch0_oe = ctrl_r.out_en_ch0;
    assign pwm_out_ch1_oe = ctrl_r.out_en_ch1;

    // ==========================================================
    // Read data, captured in the setup phase
    // ==========================================================
    logic [7:0] rd_nxt;

    always_comb begin
        rd_nxt = 8'h00;
        if (hit_ctrl) begin
            rd_nxt = ctrl_r;
        end else if (hit_d0) begin
            rd_nxt = duty_ch0_r;
        end else if (hit_d1) begin
            rd_nxt = duty_ch1_r;
        end else if (hit_stat) begin
            rd_nxt = half_cnt_r[8:1];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= {24'h00_0000, rd_nxt};
        end
    end

endmodule // dfp_top

// ### dfp_assertions.sv
module dfp_assertions #(
    parameter int HALF_CYC = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dfp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pwm_out_ch0,
    input wire logic pwm_out_ch0_oe,
    input wire logic pwm_out_ch1,
    input wire logic pwm_out_ch1_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic ctl_wr;
    logic run_r;
    logic armed_r;
    logic [1:0] mode_r;
    logic [15:0] gap_r;
    assign ctl_wr = psel && penable && pwrite && pstrb[0] && paddr == dfp_pkg::ADDR_CONTROL;
    // ========
    // Shadow of run and mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 1'b0;
            mode_r <= 2'b00;
        end else if (ctl_wr) begin
            run_r <= pwdata[3];
            if (!pwdata[3])
                mode_r <= 2'b00;
            else if (run_r && pwdata[1:0] != 2'b11)
                mode_r <= pwdata[1:0];
        end
    end
    // Any control write may bend one period, so it disarms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed_r <= 1'b0;
            gap_r <= 16'h0000;
        end else begin
            gap_r <= $fell(pwm_out_ch0) ? 16'h0001 : gap_r + 16'h0001;
            if (ctl_wr)
                armed_r <= 1'b0;
            else if ($fell(pwm_out_ch0))
                armed_r <= 1'b1;
        end
    end
    // ========
    // Properties
    property p_stop_high;
        !run_r && !$past(run_r) |-> pwm_out_ch0 && pwm_out_ch1;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("pin low while stopped");
    property p_idle_count;
        psel && penable && !pwrite && paddr == dfp_pkg::ADDR_STATUS && !$past(run_r) && !$past(run_r, 2)
            |-> prdata == 32'h0000_0000;
    endproperty
    a_idle_count: assert property (p_idle_count) else $error("counter not clear while stopped");
    property p_stop_clear;
        ctl_wr && !pwdata[3] |=> !pwm_out_ch0_oe && !pwm_out_ch1_oe;
    endproperty
    a_stop_clear: assert property (p_stop_clear) else $error("enables kept after stop");
    property p_enable;
        ctl_wr && run_r && pwdata[3] |=> pwm_out_ch0_oe == $past(pwdata[6]) && pwm_out_ch1_oe == $past(pwdata[7]);
    endproperty
    a_enable: assert property (p_enable) else $error("enable not taken");
    property p_oe_hold;
        !ctl_wr |=> $stable(pwm_out_ch0_oe) && $stable(pwm_out_ch1_oe);
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("enable moved without write");
    property p_start;
        $rose(run_r) |-> ##[1:4] (!pwm_out_ch0 && !pwm_out_ch1);
    endproperty
    a_start: assert property (p_start) else $error("no low pulse after start");
    property p_period;
        $fell(pwm_out_ch0) && armed_r |-> gap_r == (16'h0200 >> mode_r) * HALF_CYC;
    endproperty
    a_period: assert property (p_period) else $error("wrong period");
    property p_shared;
        run_r && $fell(pwm_out_ch0) |-> $fell(pwm_out_ch1);
    endproperty
    a_shared: assert property (p_shared) else $error("channels out of step");
endmodule // dfp_assertions

bind dfp_top dfp_assertions #(.HALF_CYC(HALF_CYC)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pwm_out_ch0(pwm_out_ch0), .pwm_out_ch0_oe(pwm_out_ch0_oe), .pwm_out_ch1(pwm_out_ch1),
    .pwm_out_ch1_oe(pwm_out_ch1_oe));

// ### dfp_load.sv
module dfp_load (
    input wire logic pclk,
    input wire logic level,
    input wire logic oe,
    output logic [9:0] width,
    output logic [9:0] width_prev
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin;
    logic [9:0] low_r = 10'h000;
    initial begin
        width = 10'h000;
        width_prev = 10'h000;
    end
    // Pull-up on the shared port pin
    assign pin = oe ? level : 1'b1;
    // Last two low pulses, so dithered pairs can be summed
    always @(posedge pclk) begin
        if (!pin) begin
            low_r <= low_r + 10'h001;
        end else if (low_r != 10'h000) begin
            width_prev <= width;
            width <= low_r;
            low_r <= 10'h000;
        end
    end
endmodule // dfp_load

// ### dual_channel_fast_pwm_tb.sv
module dual_channel_fast_pwm_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HC = 1;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, rd;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready, pslverr, out0, oe0, out1, oe1;
    logic [9:0] w0, p0, w1, p1;
    int error_cnt = 0, n_checks = 0, cyc = 0;
    always #4 pclk = ~pclk;
    dfp_top #(.HALF_CYC(HC)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pwm_out_ch0(out0), .pwm_out_ch0_oe(oe0), .pwm_out_ch1(out1), .pwm_out_ch1_oe(oe1));
    dfp_load u_ld0 (.pclk(pclk), .level(out0), .oe(oe0), .width(w0), .width_prev(p0));
    dfp_load u_ld1 (.pclk(pclk), .level(out1), .oe(oe1), .width(w1), .width_prev(p1));
    // ========
    // Helpers
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Two successive low widths in half steps; dither adds d[0] once per pair
    function automatic logic [31:0] exp2(input logic [1:0] m, input logic [7:0] d);
        case (m)
            2'b00: return 4 * d;
            2'b01: return 2 * d;
            default: return 2 * (2 * d[7:2] + d[1]) + d[0];
        endcase
    endfunction
    // ========
    // Scenarios
    task automatic t_reset();
        chk("pins", 32'h3, {oe0, oe1, out0, out1});
        apb(1'b0, dfp_pkg::ADDR_CONTROL, 32'h0);
        chk("control", dfp_pkg::CONTROL_RESET, rd);
        apb(1'b0, dfp_pkg::ADDR_DUTY_CH1, 32'h0);
        chk("duty1", dfp_pkg::DUTY_RESET, rd);
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h1, slv);
        $display("test reset done");
    endtask
    task automatic t_mode(input logic [1:0] m, input logic [7:0] d0, input logic [7:0] d1);
        logic [31:0] c;
        c = {24'h00_0000, 6'b11_0010, m};
        apb(1'b1, dfp_pkg::ADDR_CONTROL, 32'h0);
        apb(1'b1, dfp_pkg::ADDR_CONTROL, 32'h8);
        apb(1'b1, dfp_pkg::ADDR_CONTROL, c);
        apb(1'b1, dfp_pkg::ADDR_CONTROL, c | 32'h3);
        apb(1'b1, dfp_pkg::ADDR_DUTY_CH0, {24'h00_0000, d0});
        apb(1'b1, dfp_pkg::ADDR_DUTY_CH1, {24'h00_0000, d1});
        repeat (3 * (512 >> m) * HC + 8) @(posedge pclk);
        chk("ch0 widths", exp2(m, d0) * HC, w0 + p0);
        chk("ch1 widths", exp2(m, d1) * HC, w1 + p1);
        $display("test mode %0d done", m);
    endtask
    task automatic t_stop(input logic [7:0] d0);
        apb(1'b1, dfp_pkg::ADDR_CONTROL, 32'h49);
        // Enables change on the access edge, so look one cycle on
        @(posedge pclk);
        chk("enables", 32'h2, {oe0, oe1});
        apb(1'b1, dfp_pkg::ADDR_CONTROL, 32'h0);
        apb(1'b1, dfp_pkg::ADDR_DUTY_CH0, 32'h55);
        apb(1'b0, dfp_pkg::ADDR_DUTY_CH0, 32'h0);
        chk("duty0 kept", {24'h00_0000, d0}, rd);
        apb(1'b0, dfp_pkg::ADDR_CONTROL, 32'h0);
        chk("control", 32'h0, rd);
        apb(1'b0, dfp_pkg::ADDR_STATUS, 32'h0);
        chk("status", 32'h0, rd);
        chk("pins", 32'h3, {oe0, oe1, out0, out1});
        $display("test stop done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_mode(2'b00, 8'h10, 8'hf0);
        t_mode(2'b01, 8'he6, 8'h11);
        t_mode(2'b10, 8'h11, 8'h23);
        t_mode(2'b10, 8'h42, 8'hf0);
        t_stop(8'h42);
        report_and_stop();
    end
endmodule // dual_channel_fast_pwm_tb
